// file: hdl/scpm_consts.vh
// Operation
// - select 000-110 divides fast clock 1..64
// - select 111 runs system from slow clock
// - fast from fast osc, slow from slow
// - slow mode: fast osc per enable bit
// - six modes, cpu off in four
// - halt with keeps 00 enters sleep
// - sleep: slow osc only if watchdog on
// - halt with keeps 01 enters idle_low
// - halt with keeps 11 enters idle_both
// - halt with keeps 10 enters idle_fast
// - stable flag clears then sets on enable in slow mode
`ifndef SCPM_CONSTS_VH
`define SCPM_CONSTS_VH
// register byte addresses
`define SCPM_ADDR_SCC        8'h00
`define SCPM_ADDR_FOC        8'h04
`define SCPM_ADDR_MODE       8'h08
// system_clock_control fields
`define SCPM_SEL_HI          7
`define SCPM_SEL_LO          5
`define SCPM_FKEEP_BIT       1
`define SCPM_SKEEP_BIT       0
`define SCPM_SCC_RESET       8'h00
`define SCPM_SEL_SLOW        3'h7
// fast_osc_control fields
`define SCPM_FREQ_HI         3
`define SCPM_FREQ_LO         2
`define SCPM_STABLE_BIT      1
`define SCPM_FEN_BIT         0
`define SCPM_FOC_RESET       8'h01
// fast osc start-up time in ns, and cycles at 50 ns
`define SCPM_FAST_START_NS   1000
`define SCPM_CLK_NS          50
`define SCPM_FAST_START_CYC  ((`SCPM_FAST_START_NS + `SCPM_CLK_NS - 1) / `SCPM_CLK_NS)
`endif

// file: hdl/scpm_fast_div.v
`timescale 1ns/1ns
`include "scpm_consts.vh"
// divides fast clock ticks by 2^sel (by 64 for sel 7), emits one-cycle enable
module scpm_fast_div (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       fast_tick,
  input  wire [2:0] sel,
  output reg        div_tick
);
  reg [5:0] cnt;  // free running tick counter
  wire [5:0] mask = (6'h01 << sel) - 6'h01;
  // count fast ticks; pulse when masked low bits wrap
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt      <= 6'h00;
      div_tick <= 1'b0;
    end else begin
      div_tick <= fast_tick && ((cnt & mask) == mask);
      if (fast_tick)
        cnt <= cnt + 6'h01;
    end
  end
endmodule

// file: hdl/scpm_osc_stable.v
`timescale 1ns/1ns
`include "scpm_consts.vh"
// stability timer for the fast oscillator
module scpm_osc_stable #(
  parameter [15:0] START_CYC = `SCPM_FAST_START_CYC
) (
  input  wire hclk,
  input  wire hresetn,
  input  wire osc_on,
  output reg  stable
);
  reg [15:0] cnt;  // cycles since oscillator started
  // flag drops while off, rises after start-up time
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt    <= 16'h0000;
      stable <= 1'b0;
    end else if (!osc_on) begin
      cnt    <= 16'h0000;
      stable <= 1'b0;
    end else if (cnt >= START_CYC - 16'h0001) begin
      stable <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// file: hdl/scpm_clk_ctrl.v
`timescale 1ns/1ns
`include "scpm_consts.vh"
// system clock select and operating mode control, ahb-lite slave
module scpm_clk_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        fast_rc_tick,
  input  wire        slow_rc_tick,
  input  wire        halt_exec,
  input  wire        wake,
  input  wire        wdt_enable,
  output reg         sys_clk_en,
  output reg         fast_clk_en,
  output reg         sub_clk_en,
  output reg         slow_rc_clk_on,
  output reg         fast_osc_run,
  output reg         cpu_run,
  output reg  [5:0]  op_mode
);
  // one-hot operating modes
  localparam [5:0] M_FAST      = 6'h01;
  localparam [5:0] M_SLOW      = 6'h02;
  localparam [5:0] M_SLEEP     = 6'h04;
  localparam [5:0] M_IDLE_LOW  = 6'h08;
  localparam [5:0] M_IDLE_BOTH = 6'h10;
  localparam [5:0] M_IDLE_FAST = 6'h20;

  reg  [2:0] sysclk_select;       // system clock source/divider
  reg        fast_osc_idle_keep;  // fast osc kept in halt
  reg        slow_osc_idle_keep;  // slow osc kept in halt
  reg  [1:0] fast_osc_freq_sel;   // frequency select, stored only
  reg        fast_osc_enable;     // fast osc enable in slow mode
  reg  [5:0] mode;                // current operating mode
  reg  [5:0] next_mode;           // mode for next cycle
  reg        ph_wr;               // data phase is a write
  reg  [7:0] ph_addr;             // latched address
  wire       fast_osc_stable;     // from stability timer
  wire       div_tick;            // divided fast ticks
  reg        osc_on;              // fast oscillator powered
  reg        next_sys;            // next system clock enable
  reg        next_fast;           // next fast clock enable
  reg        next_sub;            // next sub clock enable
  reg        next_slow_rc_osc;           // next slow osc run
  reg [31:0] next_rdata;          // read mux

  wire slow_sel = (sysclk_select == `SCPM_SEL_SLOW);
  wire access   = hsel && hready && htrans[1];

  // fast osc runs in fast mode, slow mode per enable, idles keeping it
  always @* begin
    case (mode)
      M_FAST:      osc_on = 1'b1;
      M_SLOW:      osc_on = fast_osc_enable;
      M_IDLE_BOTH: osc_on = 1'b1;
      M_IDLE_FAST: osc_on = 1'b1;
      default:     osc_on = 1'b0;
    endcase
  end

  // fast clock ticks count whenever the oscillator is powered, settled or not
  scpm_fast_div u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .fast_tick (fast_rc_tick & osc_on),
    .sel       (sysclk_select),
    .div_tick  (div_tick)
  );

  scpm_osc_stable u_stable (
    .hclk    (hclk),
    .hresetn (hresetn),
    .osc_on  (osc_on),
    .stable  (fast_osc_stable)
  );

  // mode sequencing: halt picks low-power mode, wake returns
  always @* begin
    next_mode = mode;
    case (mode)
      M_FAST, M_SLOW: begin
        if (halt_exec) begin
          case ({fast_osc_idle_keep, slow_osc_idle_keep})
            2'b00:   next_mode = M_SLEEP;
            2'b01:   next_mode = M_IDLE_LOW;
            2'b11:   next_mode = M_IDLE_BOTH;
            default: next_mode = M_IDLE_FAST;
          endcase
        end else begin
          next_mode = slow_sel ? M_SLOW : M_FAST;
        end
      end
      M_SLEEP, M_IDLE_LOW, M_IDLE_BOTH, M_IDLE_FAST: begin
        if (wake)
          next_mode = slow_sel ? M_SLOW : M_FAST;
      end
      default: next_mode = M_FAST;
    endcase
  end

  // clock enables per mode; system clock follows selected source
  always @* begin
    next_sys  = 1'b0;
    next_fast = 1'b0;
    next_sub  = 1'b0;
    next_slow_rc_osc = 1'b1;
    case (next_mode)
      M_FAST: begin
        next_sys  = div_tick;
        next_fast = fast_rc_tick;
        next_sub  = slow_rc_tick;
      end
      M_SLOW: begin
        next_sys  = slow_rc_tick;
        next_fast = fast_rc_tick & fast_osc_enable;
        next_sub  = slow_rc_tick;
      end
      M_SLEEP: begin
        next_slow_rc_osc = wdt_enable;
      end
      M_IDLE_LOW: begin
        next_sys  = slow_sel & slow_rc_tick;
        next_sub  = slow_rc_tick;
      end
      M_IDLE_BOTH: begin
        next_sys  = slow_sel ? slow_rc_tick : div_tick;
        next_fast = fast_rc_tick;
        next_sub  = slow_rc_tick;
      end
      M_IDLE_FAST: begin
        next_sys  = ~slow_sel & div_tick;
        next_fast = fast_rc_tick;
      end
      default: begin
        next_slow_rc_osc = 1'b1;
      end
    endcase
  end

  // read mux on the address phase, so data stands through the data phase
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      `SCPM_ADDR_SCC:
        next_rdata = {24'h000000, sysclk_select, 3'h0,
                      fast_osc_idle_keep, slow_osc_idle_keep};
      `SCPM_ADDR_FOC:
        next_rdata = {28'h0000000, fast_osc_freq_sel,
                      fast_osc_stable, fast_osc_enable};
      `SCPM_ADDR_MODE:
        next_rdata = {26'h0000000, mode};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // bus phases and register writes; zero wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr              <= 1'b0;
      ph_addr            <= 8'h00;
      sysclk_select      <= 3'h0;
      fast_osc_idle_keep <= 1'b0;
      slow_osc_idle_keep <= 1'b0;
      fast_osc_freq_sel  <= 2'h0;  // power-on value; software must set 01
      fast_osc_enable    <= 1'b1;
    end else begin
      ph_wr   <= access && hwrite;
      if (access)
        ph_addr <= haddr;
      // write data lands in data phase; unmapped writes dropped
      if (ph_wr) begin
        if (ph_addr == `SCPM_ADDR_SCC) begin
          sysclk_select      <= hwdata[`SCPM_SEL_HI:`SCPM_SEL_LO];
          fast_osc_idle_keep <= hwdata[`SCPM_FKEEP_BIT];
          slow_osc_idle_keep <= hwdata[`SCPM_SKEEP_BIT];
        end else if (ph_addr == `SCPM_ADDR_FOC) begin
          fast_osc_freq_sel  <= hwdata[`SCPM_FREQ_HI:`SCPM_FREQ_LO];
          fast_osc_enable    <= hwdata[`SCPM_FEN_BIT];
        end
      end
    end
  end

  // registered outputs: read data, clock enables and mode
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata         <= 32'h0000_0000;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      mode           <= M_FAST;
      sys_clk_en     <= 1'b0;
      fast_clk_en    <= 1'b0;
      sub_clk_en     <= 1'b0;
      slow_rc_clk_on <= 1'b1;
      fast_osc_run   <= 1'b1;
      cpu_run        <= 1'b1;
      op_mode        <= M_FAST;
    end else begin
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      // read data captured at the address edge so it stands in the data phase;
      // a read right behind a write to the same register sees the old value
      if (access && !hwrite)
        hrdata <= next_rdata;
      mode           <= next_mode;
      sys_clk_en     <= next_sys;
      fast_clk_en    <= next_fast;
      sub_clk_en     <= next_sub;
      slow_rc_clk_on <= next_slow_rc_osc;
      fast_osc_run   <= osc_on;
      cpu_run        <= (next_mode == M_FAST) || (next_mode == M_SLOW);
      op_mode        <= next_mode;
    end
  end
endmodule

// file: bench/scpm_clk_ctrl_asserts.sv
`timescale 1ns/1ns
// port checker; shadows the idle-keep bits from bus writes to predict halt targets
module scpm_clk_ctrl_asserts (
  input wire       hclk,
  input wire       hresetn,
  input wire       hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire [31:0] hwdata,
  input wire       halt_exec,
  input wire       wdt_enable,
  input wire       hreadyout,
  input wire       hresp,
  input wire       sys_clk_en,
  input wire       fast_clk_en,
  input wire       sub_clk_en,
  input wire       slow_rc_clk_on,
  input wire       fast_osc_run,
  input wire       cpu_run,
  input wire [5:0] op_mode
);
  reg       wr_pend; // select register write in data phase
  reg [1:0] keep_q;  // shadow of the two idle-keep bits
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow update at the data-phase edge, as the slave stores it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      keep_q  <= 2'b00;
    end else begin
      wr_pend <= hsel && htrans[1] && hwrite && (haddr == 8'h00);
      if (wr_pend) keep_q <= hwdata[1:0];
    end
  end
  a_mode_one_hot: assert property ($onehot(op_mode)) else $error("mode not one-hot");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
  a_cpu_off_lp: assert property (|op_mode[5:2] && $past(|op_mode[5:2]) |-> !cpu_run)
    else $error("cpu runs in low power");
  a_halt_entry: assert property (halt_exec && cpu_run |-> ##[1:3] op_mode == (
    keep_q == 2'b00 ? 6'h04 : keep_q == 2'b01 ? 6'h08 : keep_q == 2'b11 ? 6'h10 : 6'h20))
    else $error("wrong halt target");
  a_sleep_clocks: assert property (op_mode[2] && $past(op_mode[2])
    |-> !(sys_clk_en | fast_clk_en | sub_clk_en)) else $error("clock in sleep");
  a_sleep_slow_rc_osc: assert property (op_mode[2] && $past(op_mode[2]) && $stable(wdt_enable)
    |-> slow_rc_clk_on == wdt_enable) else $error("slow osc vs watchdog");
  a_idle_low_fast: assert property (op_mode[3] && $past(op_mode[3]) |-> !fast_clk_en)
    else $error("fast clock in idle_low");
  a_idle_fast_sub: assert property (op_mode[5] && $past(op_mode[5]) |-> !sub_clk_en)
    else $error("sub clock in idle_fast");
  a_fast_osc_on: assert property (op_mode[0] && $past(op_mode[0]) |-> fast_osc_run)
    else $error("fast osc off in fast mode");
endmodule
bind scpm_clk_ctrl scpm_clk_ctrl_asserts scpm_clk_ctrl_asserts_inst (.*);

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
  logic hclk, hresetn, hsel, hwrite, fast_rc_tick, slow_rc_tick, halt_exec, wake, wdt_enable;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, sel;
  logic [31:0] hwdata, hrdata, r;
  logic hreadyout, hresp, sys_clk_en, fast_clk_en, sub_clk_en, slow_rc_clk_on, fast_osc_run;
  logic cpu_run;
  logic [5:0] op_mode;
  wire hready = hreadyout; // single slave drives the bus ready
  int error_cnt = 0, checked = 0, n = 0, n0, e, i, k = 0;
  // rows: select, idle keeps, watchdog, mode expected after halt
  logic [11:0] rows [8] = '{{3'd0, 2'b00, 1'b0, 6'h04}, {3'd1, 2'b01, 1'b0, 6'h08},
    {3'd2, 2'b11, 1'b0, 6'h10}, {3'd3, 2'b10, 1'b0, 6'h20}, {3'd4, 2'b00, 1'b1, 6'h04},
    {3'd6, 2'b01, 1'b0, 6'h08}, {3'd7, 2'b11, 1'b0, 6'h10}, {3'd7, 2'b00, 1'b1, 6'h04}};
  scpm_clk_ctrl scpm_clk_ctrl_inst (.*);
  always #25 hclk = ~hclk;
  // slow oscillator ticks once every 8 bus cycles
  always @(posedge hclk) begin
    k <= (k + 1) % 8;
    slow_rc_tick <= (k == 0);
    if (sys_clk_en === 1'b1) n <= n + 1;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single ahb transfer; read data taken at the edge that ends the data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // halt or wake pulse of one cycle
  task pulse(input logic h);
    @(posedge hclk);
    if (h) halt_exec <= 1; else wake <= 1;
    @(posedge hclk);
    halt_exec <= 0; wake <= 0;
    repeat (4) @(posedge hclk);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; fast_rc_tick = 1; slow_rc_tick = 0; halt_exec = 0; wake = 0; wdt_enable = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    ahb(0, 8'h00, 0); chk("scc reset", r, 32'h0);
    ahb(0, 8'h04, 0); chk("foc reset", r, 32'h1);
    ahb(0, 8'h08, 0); chk("mode reset", r, 32'h1);
    ahb(1, 8'h0c, 32'hff); ahb(0, 8'h0c, 0); chk("unmapped", r, 32'h0);
    for (i = 0; i < 8; i++) begin
      sel = rows[i][11:9];
      wdt_enable <= rows[i][6];
      ahb(1, 8'h00, {24'h0, sel, 3'h0, rows[i][8:7]});
      repeat (20) @(posedge hclk);
      n0 = n; e = (sel == 3'd7) ? 16 : 128 >> sel;
      repeat (128) @(posedge hclk);
      chk("sysclk rate", 32'(n - n0 >= e - 1 && n - n0 <= e + 1), 32'h1);
      chk("run mode", op_mode, (sel == 3'd7) ? 32'h2 : 32'h1);
      pulse(1);
      chk("halt mode", op_mode, rows[i][5:0]);
      chk("cpu off", cpu_run, 1'b0);
      if (rows[i][2]) chk("slow osc", slow_rc_clk_on, rows[i][6]);
      pulse(0);
      chk("wake mode", op_mode, (sel == 3'd7) ? 32'h2 : 32'h1);
    end
    ahb(1, 8'h04, 32'h4); repeat (3) @(posedge hclk);
    chk("fast osc off", fast_osc_run, 1'b0);
    ahb(0, 8'h04, 0); chk("stable off", r, 32'h4);
    ahb(1, 8'h04, 32'h5); ahb(0, 8'h04, 0); chk("stable clear", r, 32'h5);
    repeat (25) @(posedge hclk);
    ahb(0, 8'h04, 0); chk("stable set", r, 32'h7);
    end_of_test;
  end
endmodule
